// [core/board_irq_pkg.sv]
package board_irq_pkg;

   // ------------------------------------------------------------
   // clock and tick timing
   // ------------------------------------------------------------
   localparam int CLK_HZ = 200_000_000;
   localparam int REF_HZ_50 = 50;
   localparam int REF_HZ_60 = 60;
   // one full reference period; a longest time rounds down
   localparam int TICK_CYCLES_50 = CLK_HZ / REF_HZ_50;
   localparam int TICK_CYCLES_60 = CLK_HZ / REF_HZ_60;
   localparam int TICK_CNT_W = 22;

   // ------------------------------------------------------------
   // port map
   // ------------------------------------------------------------
   // the tick_timer_port of the board, counted from zero
   localparam logic [4:0] TIMER_PORT_IDX = 5'h10;
   localparam int TIMER_IDLE_BIT = 0;
   localparam int N_SRC = 8;
   localparam int N_VI = 8;

   typedef enum logic [1:0] {
      ARB_CHAIN,
      ARB_VI,
      ARB_ADDR
   } arb_mode_t;

   // strap choice for one code byte bit
   typedef enum logic [2:0] {
      SEL_OPEN,
      SEL_GROUND,
      SEL_IDX0,
      SEL_IDX1,
      SEL_IDX2
   } code_sel_t;

   // every pin and strap, as seen after the synchroniser
   typedef struct packed {
      logic port_sel;
      logic port_rd;
      logic port_wr;
      logic [4:0] port_addr;
      logic inta;
      logic [2:0] addr_level;
      logic [7:0] serial_req;
      logic chain_in;
      logic [7:0] vi_n_in;
      logic rate_select_strap;
      logic irq_enable_strap;
      logic main_line_drive_option;
      logic vi_enable;
      logic [2:0] vi_select;
      logic [1:0] arb_mode;
      logic [2:0] board_priority;
      logic [7:0] map_conn;
      logic [23:0] prio_map;
      logic [23:0] code_sel;
   } pins_t;

endpackage

// [core/tick_divider.sv]
`timescale 1ns/1ps
`default_nettype none
module tick_divider #(
   parameter int CYC_A = board_irq_pkg::TICK_CYCLES_50,
   parameter int CYC_B = board_irq_pkg::TICK_CYCLES_60,
   parameter int W = board_irq_pkg::TICK_CNT_W
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic sel_a,
   output logic tick
);

   typedef struct packed {
      logic [W-1:0] cnt;
      logic tick;
   } div_t;

   div_t s_q;
   div_t s_d;
   logic [W-1:0] last;

   // the reference never stops, whatever the timer is doing
   always_comb begin
      s_d = s_q;
      last = sel_a ? W'(CYC_A - 1) : W'(CYC_B - 1);
      s_d.tick = 1'b0;
      if (s_q.cnt >= last) begin
         s_d.cnt = '0;
         s_d.tick = 1'b1;
      end else begin
         s_d.cnt = s_q.cnt + W'(1);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign tick = s_q.tick;

   AST_TICK_SINGLE: assert property (@(posedge clk) disable iff (rst) tick |=> !tick)
      else $error("tick lasted more than one cycle");

endmodule
`default_nettype wire

// [core/request_encoder.sv]
`timescale 1ns/1ps
`default_nettype none
module request_encoder #(
   parameter int N = board_irq_pkg::N_SRC
) (
   input wire logic [N-1:0] req,
   input wire logic [N-1:0] conn,
   input wire logic [3*N-1:0] level_map,
   output logic valid,
   output logic [2:0] index
);

   logic [N-1:0] lvl_req [N];
   logic [N-1:0] level;

   // each source lands on the level its strap names; open sources drop out
   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_src
         always_comb begin
            lvl_req[g] = '0;
            lvl_req[g][level_map[3*g +: 3]] = req[g] & conn[g];
         end
      end
   endgenerate

   always_comb begin
      level = '0;
      for (int s = 0; s < N; s++) begin
         level = level | lvl_req[s];
      end
   end

   // level 7 is the highest priority
   always_comb begin
      valid = |level;
      index = 3'h0;
      for (int l = 0; l < N; l++) begin
         if (level[l]) begin
            index = 3'(l);
         end
      end
   end

endmodule
`default_nettype wire

// [core/board_interrupt_vectoring.sv]
// What this block does
// - timer trips once per full 50 or 60 Hz reference period, reference always runs.
// - rate strap connected picks 50 Hz, open picks 60 Hz.
// - once tripped, the timer request holds until software resets the timer.
// - any byte written to the tick_timer_port clears and rearms the timer.
// - reading the tick_timer_port gives bit 0 low when tripped, high otherwise.
// - timer request shares the first serial channel's encoder input.
// - eight requests pass a strap mapping; highest active level is the requester.
// - no request reaches the bus without the interrupt-enable strap.
// - requests may drive the main line or one vectored line, never non-maskable.
// - main-line option drives the main line independent of vectored selection.
// - at most one vectored line is driven at a time.
// - a chain input from above and chain output to below are provided.
// - chain input disables this board; while serviced it asserts chain output.
// - arbitration modes are chain only, vectored-line priority, address-line level.
// - code byte goes on the bus in acknowledge only when arbitration allows.
// - vectored mode answers when highest active line's number equals board priority.
// - address mode answers when host level on address bits 1-3 matches.
// - answer is one byte, usable as instruction, identifier or vector.
// - code byte can form restart instructions from restart zero to restart seven.
// - encoder gives three requester-index lines to the code header.
// - open code bits read zero, grounded ones read one.
// - each code bit may be a fixed level or a requester-index line.
`timescale 1ns/1ps
`default_nettype none
module board_interrupt_vectoring #(
   parameter int TICK_CYCLES_50 = board_irq_pkg::TICK_CYCLES_50,
   parameter int TICK_CYCLES_60 = board_irq_pkg::TICK_CYCLES_60
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic port_sel,
   input wire logic [4:0] port_addr,
   input wire logic port_rd,
   input wire logic port_wr,
   output logic [7:0] data_out,
   output logic data_oe,
   input wire logic inta,
   input wire logic [2:0] addr_level,
   input wire logic [7:0] serial_req,
   input wire logic chain_in,
   output logic chain_out,
   output logic int_n_out,
   output logic int_n_oe,
   input wire logic [7:0] vi_n_in,
   output logic [7:0] vi_n_out,
   output logic [7:0] vi_n_oe,
   input wire logic rate_select_strap,
   input wire logic irq_enable_strap,
   input wire logic main_line_drive_option,
   input wire logic vi_enable,
   input wire logic [2:0] vi_select,
   input wire logic [1:0] arb_mode,
   input wire logic [2:0] board_priority,
   input wire logic [7:0] map_conn,
   input wire logic [23:0] prio_map,
   input wire logic [23:0] code_sel
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      board_irq_pkg::pins_t in1;
      board_irq_pkg::pins_t in2;
      logic wr_prev;
      logic tripped;
      logic [7:0] data_out;
      logic data_oe;
      logic int_oe;
      logic [7:0] vi_oe;
      logic chain_out;
   } state_t;

   state_t s_q;
   state_t s_d;
   board_irq_pkg::pins_t pins_raw;
   board_irq_pkg::pins_t p;
   logic tick;
   logic enc_valid;
   logic [2:0] enc_index;
   logic [7:0] enc_req;
   logic wr_fire;
   logic rd_hit;
   logic req_live;
   logic arb_ok;
   logic ack_win;
   logic [3:0] vi_win;
   logic [7:0] code_byte;

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic code_bit(input logic [2:0] sel, input logic [2:0] idx);
      logic b;
      case (board_irq_pkg::code_sel_t'(sel))
         board_irq_pkg::SEL_GROUND: b = 1'b1;
         board_irq_pkg::SEL_IDX0: b = idx[0];
         board_irq_pkg::SEL_IDX1: b = idx[1];
         board_irq_pkg::SEL_IDX2: b = idx[2];
         default: b = 1'b0;
      endcase
      return b;
   endfunction

   // bit 3 flags any line active; vi line 0 carries priority number 7
   function automatic logic [3:0] vi_number(input logic [7:0] act);
      logic [3:0] r;
      r = 4'h0;
      for (int k = 7; k >= 0; k--) begin
         if (act[k]) begin
            r = {1'b1, 3'(7 - k)};
         end
      end
      return r;
   endfunction

   // ------------------------------------------------------------
   // sub-blocks
   // ------------------------------------------------------------
   // a connected rate strap reads high and picks the slower rate
   tick_divider #(
      .CYC_A(TICK_CYCLES_50),
      .CYC_B(TICK_CYCLES_60),
      .W(board_irq_pkg::TICK_CNT_W)
   ) u_div (
      .clk(clk),
      .rst(rst),
      .sel_a(p.rate_select_strap),
      .tick(tick)
   );

   // timer shares source 0 with the first serial channel; software polls its status
   assign enc_req = p.serial_req | {7'h00, s_q.tripped};

   request_encoder #(
      .N(board_irq_pkg::N_SRC)
   ) u_enc (
      .req(enc_req),
      .conn(p.map_conn),
      .level_map(p.prio_map),
      .valid(enc_valid),
      .index(enc_index)
   );

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      pins_raw = '{port_sel, port_rd, port_wr, port_addr, inta, addr_level, serial_req, chain_in,
                   vi_n_in, rate_select_strap, irq_enable_strap, main_line_drive_option, vi_enable,
                   vi_select, arb_mode, board_priority, map_conn, prio_map, code_sel};
   end

   assign p = s_q.in2;

   always_comb begin
      s_d = s_q;
      // all pins cross in through two flops; only the second is read
      s_d.in1 = pins_raw;
      s_d.in2 = s_q.in1;
      s_d.wr_prev = p.port_wr;

      wr_fire = p.port_wr & ~s_q.wr_prev & p.port_sel & (p.port_addr == board_irq_pkg::TIMER_PORT_IDX);
      rd_hit = p.port_rd & p.port_sel & (p.port_addr == board_irq_pkg::TIMER_PORT_IDX);

      // the written value is irrelevant; a new trip in the same cycle wins
      if (wr_fire) begin
         s_d.tripped = 1'b0;
      end
      if (tick) begin
         s_d.tripped = 1'b1;
      end

      // chain input from above silences this board's request lines and acknowledge answer; port reads still answer
      req_live = enc_valid & p.irq_enable_strap & ~p.chain_in;
      s_d.int_oe = req_live & p.main_line_drive_option;
      s_d.vi_oe = '0;
      if (req_live && p.vi_enable) begin
         s_d.vi_oe[p.vi_select] = 1'b1;
      end
      s_d.chain_out = p.chain_in | (enc_valid & p.irq_enable_strap);

      vi_win = vi_number(~p.vi_n_in);
      case (board_irq_pkg::arb_mode_t'(p.arb_mode))
         board_irq_pkg::ARB_VI: arb_ok = vi_win[3] & (vi_win[2:0] == p.board_priority);
         board_irq_pkg::ARB_ADDR: arb_ok = (p.addr_level == p.board_priority);
         default: arb_ok = 1'b1;
      endcase
      ack_win = p.inta & req_live & arb_ok;

      for (int b = 0; b < 8; b++) begin
         code_byte[b] = code_bit(p.code_sel[3*b +: 3], enc_index);
      end

      // acknowledge wins over a port read; the bus is released as soon as it ends
      if (ack_win) begin
         s_d.data_oe = 1'b1;
         s_d.data_out = code_byte;
      end else if (rd_hit) begin
         s_d.data_oe = 1'b1;
         s_d.data_out = 8'h00;
         s_d.data_out[board_irq_pkg::TIMER_IDLE_BIT] = ~s_q.tripped;
      end else begin
         s_d.data_oe = 1'b0;
         s_d.data_out = 8'h00;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign data_out = s_q.data_out;
   assign data_oe = s_q.data_oe;
   assign chain_out = s_q.chain_out;
   // open-drain lines only ever pull low; the non-maskable line has no driver here
   assign int_n_out = 1'b0;
   assign int_n_oe = s_q.int_oe;
   assign vi_n_out = 8'h00;
   assign vi_n_oe = s_q.vi_oe;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   AST_TRIP_STICKY: assert property (@(posedge clk) disable iff (rst)
      s_q.tripped && !wr_fire |=> s_q.tripped)
      else $error("timer request dropped without a reset write");

   AST_WRITE_CLEARS: assert property (@(posedge clk) disable iff (rst)
      wr_fire && !tick |=> !s_q.tripped)
      else $error("port write did not clear the timer");

   AST_TICK_SETS: assert property (@(posedge clk) disable iff (rst)
      tick |=> s_q.tripped)
      else $error("tick did not trip the timer");

   AST_READ_BIT0: assert property (@(posedge clk) disable iff (rst)
      rd_hit && !ack_win |=> data_oe && (data_out[0] == !$past(s_q.tripped)) && (data_out[7:1] == 7'h00))
      else $error("timer port read returned a wrong value");

   AST_NO_IRQ_WITHOUT_ENABLE: assert property (@(posedge clk) disable iff (rst)
      !p.irq_enable_strap |=> !int_n_oe && (vi_n_oe == 8'h00))
      else $error("request drove the bus while interrupts are disabled");

   AST_ONE_VI: assert property (@(posedge clk) disable iff (rst)
      $onehot0(vi_n_oe))
      else $error("more than one vectored line driven");

   AST_CHAIN_BLOCKS: assert property (@(posedge clk) disable iff (rst)
      p.chain_in |=> chain_out && !int_n_oe && (vi_n_oe == 8'h00))
      else $error("chain input did not disable this board");

   AST_CODE_ONLY_WON: assert property (@(posedge clk) disable iff (rst)
      $rose(data_oe) |-> $past(ack_win) || $past(rd_hit))
      else $error("data bus driven outside a won acknowledge or port read");

   AST_ADDR_MATCH: assert property (@(posedge clk) disable iff (rst)
      ack_win && (p.arb_mode == 2'h2) |=> data_oe && ($past(p.addr_level) == $past(p.board_priority)))
      else $error("address mode answered a foreign level");

   AST_REFUSED_SILENT: assert property (@(posedge clk) disable iff (rst)
      p.inta && !arb_ok && !rd_hit |=> !data_oe)
      else $error("code byte driven although arbitration failed");

   AST_VI_SELECTED: assert property (@(posedge clk) disable iff (rst)
      req_live && p.vi_enable |=> vi_n_oe == (8'h01 << $past(p.vi_select)))
      else $error("wrong vectored line driven");

   AST_MAIN_OPTION: assert property (@(posedge clk) disable iff (rst)
      !p.main_line_drive_option |=> !int_n_oe)
      else $error("main line driven with its option off");

   AST_BUS_RELEASE: assert property (@(posedge clk) disable iff (rst)
      !ack_win && !rd_hit |=> !data_oe)
      else $error("data bus held after the cycle ended");

   AST_CHAIN_SERVICED: assert property (@(posedge clk) disable iff (rst)
      enc_valid && p.irq_enable_strap |=> chain_out)
      else $error("pending request did not hold off lower boards");

   AST_CODE_OPEN: assert property (@(posedge clk) disable iff (rst)
      ack_win && (p.code_sel == 24'h00_0000) |=> data_out == 8'h00)
      else $error("open code header did not read zero");

   AST_CODE_GROUND: assert property (@(posedge clk) disable iff (rst)
      ack_win && (p.code_sel == 24'h24_9249) |=> data_out == 8'hFF)
      else $error("grounded code header did not read all ones");

   COV_TICK_CLEAR: cover property (@(posedge clk) disable iff (rst) tick ##[1:20] wr_fire);
   COV_VI_WIN: cover property (@(posedge clk) disable iff (rst) ack_win && (p.arb_mode == 2'h1));
   COV_ADDR_WIN: cover property (@(posedge clk) disable iff (rst) ack_win && (p.arb_mode == 2'h2));
   COV_CHAIN_HOLD: cover property (@(posedge clk) disable iff (rst) p.chain_in && enc_valid);

endmodule
`default_nettype wire

// [sim/host_bus_model.sv]
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
   input wire logic clk,
   input wire logic [7:0] data_out,
   input wire logic data_oe,
   output logic port_sel,
   output logic [4:0] port_addr,
   output logic port_rd,
   output logic port_wr,
   output logic inta,
   output logic [2:0] addr_level
);
   initial begin
      port_sel = 1'b0;
      port_addr = 5'h00;
      port_rd = 1'b0;
      port_wr = 1'b0;
      inta = 1'b0;
      addr_level = 3'h0;
   end

   // ------------------------------------------------------------
   // one bus cycle: 0 read, 1 write, 2 acknowledge
   // ------------------------------------------------------------
   // the answer needs two sync stages and a register, so the strobe
   // is held four cycles and the answer taken at the end of the hold
   task automatic cycle(input int kind, input logic [4:0] addr, input logic [2:0] lvl,
                        output logic [7:0] data, output logic oe);
      @(negedge clk);
      port_addr = addr;
      addr_level = lvl;
      port_sel = (kind != 2);
      port_rd = (kind == 0);
      port_wr = (kind == 1);
      inta = (kind == 2);
      repeat (4) @(negedge clk);
      data = data_out;
      oe = data_oe;
      port_sel = 1'b0;
      port_rd = 1'b0;
      port_wr = 1'b0;
      inta = 1'b0;
      // released lines do not keep their last value
      port_addr = ~addr;
      addr_level = ~lvl;
      repeat (4) @(negedge clk);
   endtask
endmodule
`default_nettype wire

// [sim/test_board_interrupt_vectoring.sv]
`timescale 1ns/1ps
`default_nettype none
module test_board_interrupt_vectoring;
   localparam int T50 = 200;
   localparam int T60 = 170;
   localparam int LIMIT = 20000;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic port_sel, port_rd, port_wr, inta, chain_in, chain_out, int_n_out, int_n_oe, data_oe;
   logic rate_select_strap, irq_enable_strap, main_line_drive_option, vi_enable;
   logic [4:0] port_addr;
   logic [2:0] addr_level, vi_select, board_priority;
   logic [1:0] arb_mode;
   logic [7:0] data_out, serial_req, vi_n_in, vi_n_out, vi_n_oe, map_conn, ext_vi, got_byte;
   logic [23:0] prio_map, code_sel;
   logic got_oe;
   int bad_count = 0;
   int tests_run = 0;
   int cyc = 0;

   always #2.5 clk = ~clk;
   // wired-low vectored lines: this board plus the other boards
   assign vi_n_in = ~(vi_n_oe | ext_vi);

   board_interrupt_vectoring #(.TICK_CYCLES_50(T50), .TICK_CYCLES_60(T60)) dut (
      .clk(clk), .rst(rst), .port_sel(port_sel), .port_addr(port_addr), .port_rd(port_rd),
      .port_wr(port_wr), .data_out(data_out), .data_oe(data_oe), .inta(inta),
      .addr_level(addr_level), .serial_req(serial_req), .chain_in(chain_in),
      .chain_out(chain_out), .int_n_out(int_n_out), .int_n_oe(int_n_oe), .vi_n_in(vi_n_in),
      .vi_n_out(vi_n_out), .vi_n_oe(vi_n_oe), .rate_select_strap(rate_select_strap),
      .irq_enable_strap(irq_enable_strap), .main_line_drive_option(main_line_drive_option),
      .vi_enable(vi_enable), .vi_select(vi_select), .arb_mode(arb_mode),
      .board_priority(board_priority), .map_conn(map_conn), .prio_map(prio_map),
      .code_sel(code_sel));

   host_bus_model host (
      .clk(clk), .data_out(data_out), .data_oe(data_oe), .port_sel(port_sel),
      .port_addr(port_addr), .port_rd(port_rd), .port_wr(port_wr), .inta(inta),
      .addr_level(addr_level));

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic end_sim();
      $display("tests_run=%0d bad_count=%0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic check8(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic settle();
      repeat (5) @(negedge clk);
   endtask

   task automatic ack_expect(input logic [2:0] lvl, input logic take, input logic [7:0] code);
      host.cycle(2, 5'h00, lvl, got_byte, got_oe);
      check8({7'h00, got_oe}, {7'h00, take});
      if (take) check8(got_byte, code);
      check8({7'h00, data_oe}, 8'h00);
   endtask

   task automatic wait_trip(output int t);
      int n;
      n = 0;
      while (int_n_oe !== 1'b1 && n < 400) begin
         @(negedge clk);
         n++;
      end
      t = cyc;
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic test_timer();
      int t0, t1;
      host.cycle(0, 5'h10, 3'h0, got_byte, got_oe);
      check8(got_byte, 8'h01);
      for (int s = 1; s >= 0; s--) begin
         rate_select_strap = s[0];
         host.cycle(1, 5'h10, 3'h0, got_byte, got_oe);
         wait_trip(t0);
         host.cycle(1, 5'h10, 3'h0, got_byte, got_oe);
         host.cycle(0, 5'h10, 3'h0, got_byte, got_oe);
         check8(got_byte, 8'h01);
         wait_trip(t1);
         check8(8'(t1 - t0), s ? 8'(T50) : 8'(T60));
      end
      repeat (400) @(negedge clk);
      host.cycle(0, 5'h10, 3'h0, got_byte, got_oe);
      check8(got_byte, 8'h00);
      host.cycle(0, 5'h11, 3'h0, got_byte, got_oe);
      check8({7'h00, got_oe}, 8'h00);
   endtask

   task automatic test_code();
      // bits 7,6,2..0 grounded, bits 5..3 carry the requester index
      code_sel = 24'h26_3449;
      map_conn = 8'hFF;
      for (int i = 0; i < 8; i++) begin
         serial_req = 8'h01 << i;
         settle();
         ack_expect(3'h0, 1'b1, 8'hC7 + 8'(i * 8));
      end
      map_conn = 8'hFE;
      for (int i = 0; i < 8; i++) prio_map[3*i +: 3] = 3'(7 - i);
      serial_req = 8'h24;
      settle();
      ack_expect(3'h0, 1'b1, 8'hEF);
      code_sel = 24'h24_9249;
      ack_expect(3'h0, 1'b1, 8'hFF);
      code_sel = 24'h00_0000;
      ack_expect(3'h0, 1'b1, 8'h00);
   endtask

   task automatic test_lines();
      settle();
      check8({6'h00, int_n_oe, chain_out}, 8'h03);
      check8(vi_n_oe, 8'h00);
      check8(vi_n_out | {7'h00, int_n_out}, 8'h00);
      main_line_drive_option = 1'b0;
      vi_enable = 1'b1;
      for (int s = 0; s < 8; s++) begin
         vi_select = 3'(s);
         settle();
         check8(vi_n_oe, 8'h01 << s);
         check8({7'h00, int_n_oe}, 8'h00);
      end
      irq_enable_strap = 1'b0;
      settle();
      check8({7'h00, int_n_oe} | vi_n_oe, 8'h00);
      ack_expect(3'h0, 1'b0, 8'h00);
      irq_enable_strap = 1'b1;
      chain_in = 1'b1;
      settle();
      check8({chain_out, int_n_oe} | vi_n_oe, 8'h02);
      ack_expect(3'h0, 1'b0, 8'h00);
      chain_in = 1'b0;
      serial_req = 8'h00;
      settle();
      check8({7'h00, chain_out}, 8'h00);
   endtask

   task automatic test_arb();
      serial_req = 8'h24;
      vi_select = 3'h2;
      board_priority = 3'h5;
      arb_mode = 2'h1;
      settle();
      ack_expect(3'h0, 1'b1, 8'h00);
      ext_vi = 8'h02;
      settle();
      ack_expect(3'h0, 1'b0, 8'h00);
      arb_mode = 2'h0;
      ack_expect(3'h0, 1'b1, 8'h00);
      ext_vi = 8'h00;
      arb_mode = 2'h2;
      ack_expect(3'h5, 1'b1, 8'h00);
      ack_expect(3'h4, 1'b0, 8'h00);
   endtask

   // ------------------------------------------------------------
   // main sequence and hang guard
   // ------------------------------------------------------------
   initial begin
      {serial_req, ext_vi, vi_select, board_priority, arb_mode} = '0;
      {chain_in, vi_enable, code_sel} = '0;
      {rate_select_strap, irq_enable_strap, main_line_drive_option} = 3'b111;
      map_conn = 8'h01;
      prio_map = 24'hFA_C688;
      repeat (6) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      repeat (3) @(negedge clk);
      test_timer();
      test_code();
      test_lines();
      test_arb();
      end_sim();
   end

   always @(posedge clk) begin
      cyc++;
      if (cyc == LIMIT) begin
         bad_count++;
         end_sim();
      end
   end
endmodule
`default_nettype wire
